// File: bench/parallel_nvm_programming_port_tb_top.sv
// self-checking testbench of the parallel nvm programming port
module parallel_nvm_programming_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int FLASH_CYC = 8;  // shortened busy times, all distinct
   localparam int EE_CYC    = 12;
   localparam int FUSE_CYC  = 10;
   // identity values below are arbitrary
   localparam logic [7:0] SIG [3] = '{8'hA1, 8'hB2, 8'hC3};
   localparam logic [7:0] CAL     = 8'h9D;

   logic       i_clk  = 1'b0; // 250 MHz clock
   logic       i_srst = 1'b1; // held high from time zero
   logic       ld_pin, act_hi, act_lo, pg_latch, wr_n, oe_n;
   logic [7:0] bus, o_data;
   logic       o_data_oe, o_ready_not_busy;
   int         fails      = 0;
   int         num_checks = 0;

   always #2 i_clk = ~i_clk;

   ppnvm_port #(.FLASH_CYC(FLASH_CYC), .EE_CYC(EE_CYC),
      .FUSE_CYC(FUSE_CYC), .SIG0(SIG[0]), .SIG1(SIG[1]), .SIG2(SIG[2]),
      .CAL_VALUE(CAL)) ppnvm_port_inst (
      .i_clk(i_clk), .i_srst(i_srst), .i_load_pulse_pin(ld_pin),
      .i_action_sel_hi(act_hi), .i_action_sel_lo(act_lo),
      .i_page_latch(pg_latch), .i_wr_n(wr_n), .i_oe_n(oe_n), .i_data(bus),
      .o_data(o_data), .o_data_oe(o_data_oe),
      .o_ready_not_busy(o_ready_not_busy));

   ppnvm_prog_model ppnvm_prog_model_inst (
      .i_clk(i_clk), .i_dev_data(o_data), .i_dev_data_oe(o_data_oe),
      .i_ready_not_busy(o_ready_not_busy), .o_load_pulse_pin(ld_pin),
      .o_action_sel_hi(act_hi), .o_action_sel_lo(act_lo),
      .o_page_latch(pg_latch), .o_wr_n(wr_n), .o_oe_n(oe_n), .o_bus(bus));

   // verdict and end of run, shared with the watchdog
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report

   // compare of a byte, a flag and a busy length
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected byte at %0t: %h vs %h", $time, got, exp);
      end
   endtask : check_byte
   task automatic check_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected flag at %0t: %h vs %h", $time, got, exp);
      end
   endtask : check_bit
   task automatic check_count(input int got, input int exp);
      num_checks++;
      if (got != exp) begin
         fails++;
         $display("unexpected busy at %0t: %h vs %h", $time, got, exp);
      end
   endtask : check_count

   // lock bits only ever go to 0; mode 3 shields the boot lock field
   function automatic logic [7:0] lock_next(input logic [7:0] old,
                                            input logic [7:0] d);
      if (old[1:0] == 2'b00) return old & (d | 8'h3C);
      return old & d;
   endfunction : lock_next

   // short hands over the programmer model
   task automatic ld(input logic [1:0] a, input logic s, input logic [7:0] d);
      ppnvm_prog_model_inst.load(a, s, d);
   endtask : ld
   task automatic cmd(input logic [7:0] c);
      ppnvm_prog_model_inst.load(2'b10, 1'b0, c);
   endtask : cmd
   // a negative exp skips the busy length check
   task automatic wr(input logic bsh, input logic bsl, input int exp);
      int busy;
      ppnvm_prog_model_inst.strobe(bsh, bsl, busy);
      if (exp >= 0) check_count(busy, exp);
   endtask : wr
   task automatic rd(input logic bsh, input logic bsl, input logic [7:0] exp);
      logic [7:0] d;
      logic       en;
      logic       off;
      ppnvm_prog_model_inst.read(bsh, bsl, d, en, off);
      check_byte(d, exp);
      check_bit(en, 1'b1);
      check_bit(off, 1'b0);
   endtask : rd

   // hang guard, well above the some 1900 cycles the tests need
   initial begin
      repeat (30000) @(posedge i_clk);
      fails++;
      final_report();
   end

   // main sequence
   initial begin : main_seq
      logic [15:0] fl [2][4];
      logic [7:0]  ee [4];
      logic [7:0]  fz [3];
      logic [7:0]  lkd [4];
      logic [7:0]  lk;
      void'($urandom(32'h27FBFA8D));
      lkd = '{8'hF7, 8'hFF, 8'hFC, 8'hC3};
      repeat (4) @(posedge i_clk);
      i_srst <= 1'b0;
      @(posedge i_clk);
      check_bit(o_ready_not_busy, 1'b1);
      check_bit(o_data_oe, 1'b0);
      // two flash pages differing only in the top bits of address low
      for (int p = 0; p < 2; p++) begin
         cmd(8'h10);
         for (int k = 0; k < 4; k++) begin
            fl[p][k] = 16'($urandom());
            ld(2'b00, 1'b0, {3'(p + 1), 5'(k * 10)});
            ld(2'b01, 1'b0, fl[p][k][7:0]);
            ld(2'b01, 1'b1, fl[p][k][15:8]);
         end
         ld(2'b00, 1'b1, 8'h01);
         wr(1'b0, 1'b0, FLASH_CYC);
         cmd(8'h00);
      end
      wr(1'b0, 1'b0, 0);
      cmd(8'h02);
      wr(1'b0, 1'b0, 0);
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 4; k++) begin
            ld(2'b00, 1'b0, {3'(p + 1), 5'(k * 10)});
            ld(2'b11, 1'b0, 8'($urandom()));
            rd(1'b0, 1'b0, fl[p][k][7:0]);
            rd(1'b0, 1'b1, fl[p][k][15:8]);
         end
      end
      // eeprom page of four bytes, written then read back
      cmd(8'h11);
      ld(2'b00, 1'b1, 8'h01);
      for (int k = 0; k < 4; k++) begin
         ee[k] = 8'($urandom());
         ld(2'b00, 1'b0, 8'h14 + 8'(k));
         ld(2'b01, 1'b0, ee[k]);
         ppnvm_prog_model_inst.latch();
      end
      wr(1'b0, 1'b0, EE_CYC);
      cmd(8'h03);
      for (int k = 0; k < 4; k++) begin
         ld(2'b00, 1'b0, 8'h14 + 8'(k));
         rd(1'b0, 1'b0, ee[k]);
      end
      // low, high and extended fuses picked by the selects at the strobe
      cmd(8'h40);
      for (int t = 0; t < 3; t++) begin
         fz[t] = 8'($urandom());
         ld(2'b01, 1'b0, fz[t]);
         wr(1'(t >> 1), 1'(t), FUSE_CYC);
      end
      // lock: program, try to clear, reach mode 3, try the boot field
      cmd(8'h20);
      lk = 8'hFF;
      for (int i = 0; i < 4; i++) begin
         ld(2'b01, 1'b0, lkd[i]);
         wr(1'b0, 1'b0, FUSE_CYC);
         lk = lock_next(lk, lkd[i]);
      end
      cmd(8'h04);
      rd(1'b0, 1'b0, fz[0]);
      rd(1'b1, 1'b1, fz[1]);
      rd(1'b1, 1'b0, fz[2]);
      rd(1'b0, 1'b1, lk);
      // signature bytes and calibration byte
      cmd(8'h08);
      for (int a = 0; a < 3; a++) begin
         ld(2'b00, 1'b0, 8'(a));
         rd(1'b0, 1'b0, SIG[a]);
      end
      ld(2'b00, 1'b0, 8'h00);
      rd(1'b0, 1'b1, CAL);
      final_report();
   end
endmodule : parallel_nvm_programming_port_tb_top

// File: bench/ppnvm_prog_model.sv
// programmer model that drives the parallel nvm programming pins
module ppnvm_prog_model #(
   parameter int BUSY_WIN = 40 // cycles watched after a write strobe
) (
   // clock
   input  wire logic       i_clk,
   // device outputs seen by the programmer
   input  wire logic [7:0] i_dev_data,
   input  wire logic       i_dev_data_oe,
   input  wire logic       i_ready_not_busy,
   // pins driven towards the device
   output logic            o_load_pulse_pin,
   output logic            o_action_sel_hi,
   output logic            o_action_sel_lo,
   output logic            o_page_latch,
   output logic            o_wr_n,
   output logic            o_oe_n,
   output logic [7:0]      o_bus
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       drv_en;  // programmer owns the data bus
   logic [7:0] drv_val; // last value the programmer drove

   // a released bus shows device data, else the inverse of the last value, never a stale copy
   assign o_bus = i_dev_data_oe ? i_dev_data
                                : (drv_en ? drv_val : ~drv_val);

   // pins idle at time zero: action 11, no strobe, output disabled
   initial begin
      o_load_pulse_pin = 1'b0;
      o_action_sel_hi  = 1'b1;
      o_action_sel_lo  = 1'b1;
      o_page_latch     = 1'b0;
      o_wr_n           = 1'b1;
      o_oe_n           = 1'b1;
      drv_en           = 1'b1;
      drv_val          = 8'h00;
   end

   // every level stands 4 cycles, so the device synchronisers see each edge
   task automatic hold();
      repeat (4) @(posedge i_clk);
   endtask : hold

   // one byte latched by a positive load pulse
   task automatic load(input logic [1:0] act, input logic bsl,
                       input logic [7:0] d);
      {o_action_sel_hi, o_action_sel_lo} <= act;
      o_page_latch <= bsl;
      drv_en       <= 1'b1;
      drv_val      <= d;
      hold();
      o_load_pulse_pin <= 1'b1;
      hold();
      o_load_pulse_pin <= 1'b0;
      hold();
   endtask : load

   // page latch pulse stores data low in the eeprom buffer
   task automatic latch();
      o_page_latch <= 1'b1;
      hold();
      o_page_latch <= 1'b0;
      hold();
   endtask : latch

   // negative write pulse; busy cycles counted over a bounded window,
   // long enough that ready is back before the next request
   task automatic strobe(input logic bsh, input logic bsl, output int busy);
      o_action_sel_hi <= bsh;
      o_action_sel_lo <= 1'b0;
      o_page_latch    <= bsl;
      hold();
      busy = 0;
      o_wr_n <= 1'b0;
      for (int i = 0; i < BUSY_WIN; i++) begin
         @(posedge i_clk);
         if (i == 3) o_wr_n <= 1'b1;
         if (i_ready_not_busy !== 1'b1) busy++;
      end
      {o_action_sel_hi, o_page_latch} <= 2'b00;
      hold();
   endtask : strobe

   // bus released first, then output enable low, byte taken, enable high
   task automatic read(input logic bsh, input logic bsl, output logic [7:0] d,
                       output logic en, output logic en_off);
      o_action_sel_hi <= bsh;
      o_action_sel_lo <= 1'b0;
      o_page_latch    <= bsl;
      drv_en          <= 1'b0;
      hold();
      o_oe_n <= 1'b0;
      hold();
      d  = i_dev_data;
      en = i_dev_data_oe;
      o_oe_n <= 1'b1;
      hold();
      en_off = i_dev_data_oe;
   endtask : read
endmodule : ppnvm_prog_model

// File: design/ppnvm_cfg.svh
// constants of the parallel nvm programming port
`ifndef PPNVM_CFG_SVH
`define PPNVM_CFG_SVH
// command codes latched from the data bus
`define PPNVM_CMD_NOP      8'h00
`define PPNVM_CMD_WR_FLASH 8'h10
`define PPNVM_CMD_WR_EE    8'h11
`define PPNVM_CMD_WR_FUSE  8'h40
`define PPNVM_CMD_WR_LOCK  8'h20
`define PPNVM_CMD_RD_SIG   8'h08
`define PPNVM_CMD_RD_FUSE  8'h04
`define PPNVM_CMD_RD_FLASH 8'h02
`define PPNVM_CMD_RD_EE    8'h03
// action select codes
`define PPNVM_ACT_ADDR 2'h0
`define PPNVM_ACT_DATA 2'h1
`define PPNVM_ACT_CMD  2'h2
`define PPNVM_ACT_IDLE 2'h3
// lock byte layout
`define PPNVM_LOCK_MODE_MSB 1
`define PPNVM_BOOT_LOCK_MSB 5
`define PPNVM_BOOT_LOCK_LSB 2
// reset values of fuse and lock storage
`define PPNVM_FUSE_LO_RST  8'hFF
`define PPNVM_FUSE_HI_RST  8'hFF
`define PPNVM_FUSE_EXT_RST 8'hFF
`define PPNVM_LOCK_RST     8'hFF
// timing: clock period and programming times in ns
`define PPNVM_CLK_NS        4
`define PPNVM_FLASH_PROG_NS 4000
`define PPNVM_EE_PROG_NS    4000
`define PPNVM_FUSE_PROG_NS  4000
// least times round up to whole cycles
`define PPNVM_FLASH_CYC \
   ((`PPNVM_FLASH_PROG_NS + `PPNVM_CLK_NS - 1) / `PPNVM_CLK_NS)
`define PPNVM_EE_CYC \
   ((`PPNVM_EE_PROG_NS + `PPNVM_CLK_NS - 1) / `PPNVM_CLK_NS)
`define PPNVM_FUSE_CYC \
   ((`PPNVM_FUSE_PROG_NS + `PPNVM_CLK_NS - 1) / `PPNVM_CLK_NS)
`endif

// File: design/ppnvm_pkg.sv
// types of the parallel nvm programming port
package ppnvm_pkg;
   // pending programming operation
   typedef enum logic [2:0] {
      OP_NONE,
      OP_FLASH,
      OP_EE,
      OP_FUSE,
      OP_LOCK
   } ppnvm_op_t;

   // register state of the port, apart from the storage arrays
   typedef struct packed {
      logic [13:0] sync1;   // first synchroniser stage
      logic [13:0] sync2;   // second synchroniser stage
      logic        ld_prev; // load pulse pin, last cycle
      logic        wr_prev; // write strobe, last cycle
      logic        pl_prev; // page latch, last cycle
      logic [7:0]  cmd;     // latched command
      logic [15:0] addr;    // latched address
      logic [7:0]  dlo;     // data low byte
      logic [7:0]  dhi;     // data high byte
      logic        armed;   // page buffer holds loaded data
      logic [7:0]  fuse_lo;
      logic [7:0]  fuse_hi;
      logic [7:0]  fuse_ext;
      logic [7:0]  lock;
      ppnvm_op_t   op;      // operation in progress
      logic [1:0]  fsel;    // fuse byte picked at the strobe
      logic [7:0]  wdata;   // byte captured at the strobe
      logic [15:0] page;    // address captured at the strobe
      logic [15:0] cnt;     // busy cycles left
      logic        rdy;     // ready, low while busy
      logic [7:0]  dout;    // data bus output
      logic        doe;     // data bus output enable
   } ppnvm_state_t;
endpackage : ppnvm_pkg

// File: design/ppnvm_port.sv
// device side sequencer of the parallel nvm programming port
//
// Local design decisions: the address-and-strobe port and the register offsets.
`include "ppnvm_cfg.svh"

module ppnvm_port
   import ppnvm_pkg::*;
#(
   parameter int          AW          = 10, // flash word address bits
   parameter int          PW          = 5,  // word-in-page bits
   parameter int          EW          = 9,  // eeprom address bits
   parameter int          EPW         = 2,  // byte-in-eeprom-page bits
   parameter int          FLASH_CYC   = `PPNVM_FLASH_CYC,
   parameter int          EE_CYC      = `PPNVM_EE_CYC,
   parameter int          FUSE_CYC    = `PPNVM_FUSE_CYC,
   // identity values below are arbitrary
   parameter logic [7:0]  SIG0        = 8'h5A,
   parameter logic [7:0]  SIG1        = 8'h12,
   parameter logic [7:0]  SIG2        = 8'h34,
   parameter logic [7:0]  CAL_VALUE   = 8'h80
) (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_srst,
   // programmer control pins
   input  wire logic       i_load_pulse_pin,
   input  wire logic       i_action_sel_hi,  // doubles as byte_sel_high
   input  wire logic       i_action_sel_lo,
   input  wire logic       i_page_latch,     // doubles as byte_sel_low
   input  wire logic       i_wr_n,
   input  wire logic       i_oe_n,
   // data bus, split into three signals
   input  wire logic [7:0] i_data,
   output logic      [7:0] o_data,
   output logic            o_data_oe,
   // status pin
   output logic            o_ready_not_busy
);

   ppnvm_state_t r_reg;   // registered state
   ppnvm_state_t r_next;  // next state

   // storage arrays, kept outside the struct for size
   logic [15:0] flash_mem [2**AW];
   logic [15:0] page_buf  [2**PW];
   logic [7:0]  ee_mem    [2**EW];
   logic [7:0]  ee_buf    [2**EPW];

   // decoded synchronised pins
   logic       ld, act_hi, act_lo, pl, wrn, oen;
   logic [7:0] pdata;
   logic [1:0] act;
   logic       ld_rise, pl_rise, wr_fall;
   // memory write controls
   logic       pb_we, pb_hi, eb_we, fl_commit, ee_commit;

   // unpack the second synchroniser stage only
   always_comb begin
      {ld, act_hi, act_lo, pl, wrn, oen, pdata} = r_reg.sync2;
      act     = {act_hi, act_lo};
      ld_rise = ld & ~r_reg.ld_prev;
      pl_rise = pl & ~r_reg.pl_prev;
      wr_fall = ~wrn & r_reg.wr_prev;
   end

   // read data mux for the commands that drive the bus
   function automatic logic [7:0] rd_mux(input ppnvm_state_t s,
                                         input logic bsl,
                                         input logic bsh,
                                         input logic [15:0] fw,
                                         input logic [7:0] eb);
      logic [7:0] v;
      v = 8'h00;
      unique case (s.cmd)
         `PPNVM_CMD_RD_FLASH: v = bsl ? fw[15:8] : fw[7:0];
         `PPNVM_CMD_RD_EE:    v = eb;
         `PPNVM_CMD_RD_FUSE: begin
            unique case ({bsh, bsl})
               2'h0: v = s.fuse_lo;
               2'h3: v = s.fuse_hi;
               2'h2: v = s.fuse_ext;
               default: v = s.lock;
            endcase
         end
         `PPNVM_CMD_RD_SIG: begin
            if (bsl) begin
               // calibration lives at address zero only
               v = (s.addr[7:0] == 8'h00) ? CAL_VALUE : 8'h00;
            end else begin
               unique case (s.addr[7:0])
                  8'h00:   v = SIG0;
                  8'h01:   v = SIG1;
                  8'h02:   v = SIG2;
                  default: v = 8'h00;
               endcase
            end
         end
         default: v = 8'h00;
      endcase
      return v;
   endfunction : rd_mux

   // returns high when the latched command drives the bus
   function automatic logic is_read(input logic [7:0] c);
      return (c == `PPNVM_CMD_RD_FLASH) || (c == `PPNVM_CMD_RD_EE) ||
             (c == `PPNVM_CMD_RD_FUSE) || (c == `PPNVM_CMD_RD_SIG);
   endfunction : is_read

   // next state logic
   always_comb begin
      r_next    = r_reg;
      pb_we     = 1'b0;
      pb_hi     = 1'b0;
      eb_we     = 1'b0;
      fl_commit = 1'b0;
      ee_commit = 1'b0;
      // pins come from another domain: two flops first
      r_next.sync1   = {i_load_pulse_pin, i_action_sel_hi,
                        i_action_sel_lo, i_page_latch, i_wr_n,
                        i_oe_n, i_data};
      r_next.sync2   = r_reg.sync1;
      r_next.ld_prev = ld;
      r_next.pl_prev = pl;
      r_next.wr_prev = wrn;
      // a load pulse does what the action select says
      if (ld_rise) begin
         unique case (act)
            `PPNVM_ACT_ADDR: begin
               if (pl) begin
                  r_next.addr[15:8] = pdata;
               end else begin
                  r_next.addr[7:0] = pdata;
               end
            end
            `PPNVM_ACT_DATA: begin
               if (pl) begin
                  r_next.dhi = pdata;
               end else begin
                  r_next.dlo = pdata;
               end
               // flash data goes straight into the page buffer
               if (r_reg.cmd == `PPNVM_CMD_WR_FLASH) begin
                  pb_we        = 1'b1;
                  pb_hi        = pl;
                  r_next.armed = 1'b1;
               end
            end
            `PPNVM_ACT_CMD: begin
               r_next.cmd = pdata;
               // nop drops the pending page write state
               if (pdata == `PPNVM_CMD_NOP) begin
                  r_next.armed = 1'b0;
               end
            end
            default: begin
               // idle: nothing is latched
            end
         endcase
      end
      // page latch stores the data byte for eeprom
      if (pl_rise && r_reg.cmd == `PPNVM_CMD_WR_EE) begin
         eb_we        = 1'b1;
         r_next.armed = 1'b1;
      end
      // falling strobe starts programming if the command writes
      if (wr_fall && r_reg.rdy) begin
         r_next.wdata = r_reg.dlo;
         r_next.page  = r_reg.addr;
         r_next.fsel  = {act_hi, pl};
         unique case (r_reg.cmd)
            `PPNVM_CMD_WR_FLASH: begin
               if (r_reg.armed) begin
                  r_next.op  = OP_FLASH;
                  r_next.cnt = 16'(FLASH_CYC);
               end
            end
            `PPNVM_CMD_WR_EE: begin
               if (r_reg.armed) begin
                  r_next.op  = OP_EE;
                  r_next.cnt = 16'(EE_CYC);
               end
            end
            `PPNVM_CMD_WR_FUSE: begin
               r_next.op  = OP_FUSE;
               r_next.cnt = 16'(FUSE_CYC);
            end
            `PPNVM_CMD_WR_LOCK: begin
               r_next.op  = OP_LOCK;
               r_next.cnt = 16'(FUSE_CYC);
            end
            default: begin
               // reads and nop start nothing
               r_next.op = OP_NONE;
            end
         endcase
         r_next.rdy = !((r_next.op != OP_NONE));
      end
      // busy counter, commit on the last cycle
      if (!r_reg.rdy) begin
         if (r_reg.cnt <= 16'h0001) begin
            r_next.rdy = 1'b1;
            r_next.op  = OP_NONE;
            unique case (r_reg.op)
               OP_FLASH: begin
                  fl_commit    = 1'b1;
                  r_next.armed = pb_we; // a load on this cycle wins
               end
               OP_EE: begin
                  ee_commit    = 1'b1;
                  r_next.armed = eb_we; // a latch on this cycle wins
               end
               OP_FUSE: begin
                  unique case (r_reg.fsel)
                     2'h1:    r_next.fuse_hi  = r_reg.wdata;
                     2'h2:    r_next.fuse_ext = r_reg.wdata;
                     default: r_next.fuse_lo  = r_reg.wdata;
                  endcase
               end
               OP_LOCK: begin
                  // bits only go to zero
                  r_next.lock = r_reg.lock & r_reg.wdata;
                  if (r_reg.lock[`PPNVM_LOCK_MODE_MSB:0] == 2'h0) begin
                     r_next.lock[`PPNVM_BOOT_LOCK_MSB:
                                 `PPNVM_BOOT_LOCK_LSB] =
                        r_reg.lock[`PPNVM_BOOT_LOCK_MSB:
                                   `PPNVM_BOOT_LOCK_LSB];
                  end
               end
               default: begin
                  // nothing pending
               end
            endcase
         end else begin
            r_next.cnt = r_reg.cnt - 16'h0001;
         end
      end
      // drive the bus one cycle after output enable falls
      r_next.doe  = ~oen && is_read(r_reg.cmd);
      r_next.dout = rd_mux(r_reg, pl, act_hi,
                           flash_mem[r_reg.addr[AW-1:0]],
                           ee_mem[r_reg.addr[EW-1:0]]);
   end

   // state register; command and address survive operations
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         r_reg          <= '0;
         r_reg.sync1    <= 14'h3FFF;
         r_reg.sync2    <= 14'h3FFF;
         r_reg.wr_prev  <= 1'b1;
         r_reg.ld_prev  <= 1'b1;  // syncs reset high: no false rise
         r_reg.pl_prev  <= 1'b1;
         r_reg.fuse_lo  <= `PPNVM_FUSE_LO_RST;
         r_reg.fuse_hi  <= `PPNVM_FUSE_HI_RST;
         r_reg.fuse_ext <= `PPNVM_FUSE_EXT_RST;
         r_reg.lock     <= `PPNVM_LOCK_RST;
         r_reg.op       <= OP_NONE;
         r_reg.rdy      <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // memories: low address bits pick the word, upper the page
   always_ff @(posedge i_clk) begin
      if (pb_we) begin
         if (pb_hi) begin
            page_buf[r_reg.addr[PW-1:0]][15:8] <= pdata;
         end else begin
            page_buf[r_reg.addr[PW-1:0]][7:0] <= pdata;
         end
      end
      if (eb_we) begin
         ee_buf[r_reg.addr[EPW-1:0]] <= r_reg.dlo;
      end
      // whole page is written at once on completion
      if (fl_commit) begin
         for (int i = 0; i < 2**PW; i++) begin
            flash_mem[{r_reg.page[AW-1:PW], PW'(i)}] <= page_buf[i];
         end
      end
      if (ee_commit) begin
         for (int i = 0; i < 2**EPW; i++) begin
            ee_mem[{r_reg.page[EW-1:EPW], EPW'(i)}] <= ee_buf[i];
         end
      end
   end

   // outputs straight from flops
   assign o_data           = r_reg.dout;
   assign o_data_oe        = r_reg.doe;
   assign o_ready_not_busy = r_reg.rdy;

   // checks of the sequencer
   AST_CMD_LATCH: assert property (
      @(posedge i_clk) disable iff (i_srst)
      ld_rise && act == `PPNVM_ACT_CMD |=> r_reg.cmd == $past(pdata))
      else $error("command not latched");
   AST_ADDR_LO: assert property (
      @(posedge i_clk) disable iff (i_srst)
      ld_rise && act == `PPNVM_ACT_ADDR && !pl
      |=> r_reg.addr[7:0] == $past(pdata))
      else $error("address low not latched");
   AST_ADDR_HI: assert property (
      @(posedge i_clk) disable iff (i_srst)
      ld_rise && act == `PPNVM_ACT_ADDR && pl
      |=> r_reg.addr[15:8] == $past(pdata))
      else $error("address high not latched");
   AST_DATA_LO: assert property (
      @(posedge i_clk) disable iff (i_srst)
      ld_rise && act == `PPNVM_ACT_DATA && !pl
      |=> r_reg.dlo == $past(pdata) && r_reg.dhi == $past(r_reg.dhi))
      else $error("data low byte wrong");
   AST_DATA_HI: assert property (
      @(posedge i_clk) disable iff (i_srst)
      ld_rise && act == `PPNVM_ACT_DATA && pl
      |=> r_reg.dhi == $past(pdata) && r_reg.dlo == $past(r_reg.dlo))
      else $error("data high byte wrong");
   AST_IDLE_LOAD: assert property (
      @(posedge i_clk) disable iff (i_srst)
      ld_rise && act == `PPNVM_ACT_IDLE
      |=> r_reg.cmd == $past(r_reg.cmd) && r_reg.addr == $past(r_reg.addr))
      else $error("idle load pulse changed state");
   AST_FLASH_BUSY: assert property (
      @(posedge i_clk) disable iff (i_srst)
      wr_fall && r_reg.rdy && r_reg.armed
      && r_reg.cmd == `PPNVM_CMD_WR_FLASH
      |=> !r_reg.rdy ##0 r_reg.op == OP_FLASH)
      else $error("flash page write did not go busy");
   AST_EE_BUSY: assert property (
      @(posedge i_clk) disable iff (i_srst)
      wr_fall && r_reg.rdy && r_reg.armed && r_reg.cmd == `PPNVM_CMD_WR_EE
      |=> !r_reg.rdy ##0 r_reg.op == OP_EE)
      else $error("eeprom page write did not go busy");
   AST_FUSE_BUSY: assert property (
      @(posedge i_clk) disable iff (i_srst)
      wr_fall && r_reg.rdy && r_reg.cmd == `PPNVM_CMD_WR_FUSE
      |=> !r_reg.rdy ##0 r_reg.fsel == $past({act_hi, pl}))
      else $error("fuse write did not go busy");
   AST_READ_NO_BUSY: assert property (
      @(posedge i_clk) disable iff (i_srst)
      wr_fall && r_reg.rdy && is_read(r_reg.cmd) |=> r_reg.rdy [*2])
      else $error("read command went busy");
   AST_NOP_DISARM: assert property (
      @(posedge i_clk) disable iff (i_srst)
      ld_rise && act == `PPNVM_ACT_CMD && pdata == `PPNVM_CMD_NOP
      |=> !r_reg.armed)
      else $error("nop left write state armed");
   AST_OE_ONLY: assert property (
      @(posedge i_clk) disable iff (i_srst)
      r_reg.doe |-> $past(!oen) && is_read($past(r_reg.cmd)))
      else $error("bus driven without output enable");
   AST_LOCK_NO_CLEAR: assert property (
      @(posedge i_clk) disable iff (i_srst)
      (~$past(r_reg.lock) & r_reg.lock) == 8'h00)
      else $error("lock bit cleared by write");
   AST_BOOT_LOCK: assert property (
      @(posedge i_clk) disable iff (i_srst)
      $past(r_reg.lock[1:0]) == 2'h0
      |-> r_reg.lock[5:2] == $past(r_reg.lock[5:2]))
      else $error("boot lock changed in mode 3");
   AST_BUSY_OP: assert property (
      @(posedge i_clk) disable iff (i_srst)
      !r_reg.rdy |-> r_reg.op != OP_NONE && r_reg.cnt != 16'h0000)
      else $error("busy with nothing pending");

endmodule : ppnvm_port
